// *** twi_slave.sv ***
`timescale 1ns/1ps
// Overview of operation
// (RL1) receive and transmit slave; ignore general call
// (RL2) sda fall with scl high is start
// (RL3) sda rise with scl high is stop
// (RL4) change sda only while scl low
// (RL5) one scl pulse per bit, sample high
// (RL6) master starts only on idle bus
// (RL7) seven-bit address msb first, match 1011100
// (RL8) never acknowledge 1010xxx store addresses
// (RL9) acknowledge each received byte on ninth pulse
// (RL10) master nack ends read; slave releases sda
// (RL11) write: addr, pointer, data, acks, stop
// (RL12) aborted partial byte leaves register unchanged
// (RL13) read: set pointer, restart, read, nack
// (RL14) restart keeps newly loaded pointer
// (RL15) increment pointer and ack per byte
// (RL16) pointer wraps after sixteen registers
// (RL17) byte written at its acknowledge
// (RL18) sequential read increments and wraps
// (RL19) master sets burst length; any accepted
// (RL20) interface works only in program mode
// (RL21) entering program mode clears registers
// (RL22) bus sampled through two-flop synchroniser
module twi_slave (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run_mode,
    twi_if.slave_end bus,
    output logic [twi_pkg::REG_COUNT*8-1:0] regs_flat
);
    import twi_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ADDR_ACK = 6'b000100,
        ST_WRITE = 6'b001000,
        ST_WR_ACK = 6'b010000,
        ST_READ = 6'b100000
    } state_t;

    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic mode_meta_reg, mode_sync_reg, mode_prev_reg;
    state_t state_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic ptr_set_reg;
    logic reading_reg;
    logic drive_low_reg;
    logic [7:0] regs_reg [REG_COUNT];
    logic scl_rise, scl_fall, start_cond, stop_cond, active;
    logic [7:0] rx_byte;
    logic addr_hit;

    // only second flops and their delayed copies feed logic [RL22]
    always_ff @(posedge core_clk) begin
        if (reset) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            mode_meta_reg <= 1'b1;
            mode_sync_reg <= 1'b1;
            mode_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= bus.scl;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= bus.sda;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            mode_meta_reg <= run_mode;
            mode_sync_reg <= mode_meta_reg;
            mode_prev_reg <= mode_sync_reg;
        end
    end

    assign active = !mode_sync_reg; // [RL20]
    assign scl_rise = scl_sync_reg && !scl_prev_reg;
    assign scl_fall = !scl_sync_reg && scl_prev_reg;
    // sda edge while scl steady high [RL4]
    assign start_cond = active && scl_sync_reg && scl_prev_reg
        && sda_prev_reg && !sda_sync_reg; // [RL2]
    assign stop_cond = active && scl_sync_reg && scl_prev_reg
        && !sda_prev_reg && sda_sync_reg; // [RL3]
    assign rx_byte = {shift_reg[6:0], sda_sync_reg};
    // exact match: general call and store range never hit [RL1] [RL8]
    assign addr_hit = (shift_reg[7:1] == SLAVE_ADDR); // [RL7]

    always_ff @(posedge core_clk) begin
        if (reset || !active) begin
            state_reg <= ST_IDLE;
            bit_reg <= BIT_ZERO;
            shift_reg <= BYTE_ZERO;
            reading_reg <= 1'b0;
            ptr_set_reg <= 1'b0;
        end else if (stop_cond) begin
            // partial byte simply dropped [RL12]
            state_reg <= ST_IDLE;
            bit_reg <= BIT_ZERO;
        end else if (start_cond) begin
            state_reg <= ST_ADDR; // [RL12] [RL14]
            bit_reg <= BIT_ZERO;
        end else if (scl_rise) begin
            case (state_reg)
                ST_ADDR, ST_WRITE: begin
                    // sample on high phase, msb first [RL5]
                    shift_reg <= rx_byte;
                    bit_reg <= bit_reg + 4'h1;
                end
                ST_READ: begin
                    if (bit_reg == BIT_ACK && sda_sync_reg) begin
                        state_reg <= ST_IDLE; // master nack [RL10]
                    end
                    bit_reg <= bit_reg + 4'h1;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (bit_reg == BIT_ACK) begin
                        bit_reg <= BIT_ZERO;
                        if (addr_hit) begin
                            state_reg <= ST_ADDR_ACK;
                            reading_reg <= shift_reg[0];
                            ptr_set_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    state_reg <= reading_reg ? ST_READ : ST_WRITE;
                end
                ST_WRITE: begin
                    if (bit_reg == BIT_ACK) begin
                        state_reg <= ST_WR_ACK;
                        bit_reg <= BIT_ZERO;
                    end
                end
                ST_WR_ACK: begin
                    state_reg <= ST_WRITE;
                    ptr_set_reg <= 1'b1;
                end
                ST_READ: begin
                    if (bit_reg == 4'h9) begin
                        bit_reg <= BIT_ZERO;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // pointer and register updates, both on the ack edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr_reg <= PTR_ZERO;
            for (int i = 0; i < REG_COUNT; i++) regs_reg[i] <= BYTE_ZERO;
        end else if (mode_prev_reg && !mode_sync_reg) begin
            ptr_reg <= PTR_ZERO;
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_reg[i] <= BYTE_ZERO; // [RL21]
            end
        end else if (active && scl_fall && state_reg == ST_WRITE
                     && bit_reg == BIT_ACK) begin
            if (!ptr_set_reg) begin
                ptr_reg <= shift_reg[PTR_W-1:0]; // [RL11] [RL14]
            end else begin
                regs_reg[ptr_reg] <= shift_reg; // [RL17]
                ptr_reg <= ptr_reg + PTR_ONE; // [RL15] [RL16]
            end
        end else if (active && scl_fall && state_reg == ST_READ
                     && bit_reg == BIT_ACK) begin
            ptr_reg <= ptr_reg + PTR_ONE; // [RL18] [RL16]
        end
    end

    // sda drive changes on scl fall; start, stop or leaving program mode releases it at once [RL4]
    always_ff @(posedge core_clk) begin
        if (reset || !active || stop_cond || start_cond) begin
            drive_low_reg <= 1'b0;
        end else if (scl_fall) begin
            drive_low_reg <= 1'b0;
            if (state_reg == ST_ADDR && bit_reg == BIT_ACK
                && addr_hit) begin
                drive_low_reg <= 1'b1; // [RL9]
            end else if (state_reg == ST_WRITE && bit_reg == BIT_ACK) begin
                drive_low_reg <= 1'b1; // [RL9] [RL15] [RL19]
            end else if (state_reg == ST_ADDR_ACK && reading_reg) begin
                drive_low_reg <= !regs_reg[ptr_reg][7]; // [RL13]
            end else if (state_reg == ST_READ && bit_reg <= BIT_LAST) begin
                // bits already sent count down from the msb [RL18]
                drive_low_reg <= !regs_reg[ptr_reg][BIT_LAST[2:0]
                    - bit_reg[2:0]];
            end else if (state_reg == ST_READ && bit_reg == 4'h9) begin
                drive_low_reg <= !regs_reg[ptr_reg][7]; // next byte [RL18]
            end
            // bit 8 slot falls through: sda released for master [RL10]
        end
    end

    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = !drive_low_reg;

    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) regs_flat[i*8 +: 8] = regs_reg[i];
    end
endmodule : twi_slave

// *** twi_pkg.sv ***
package twi_pkg;
    localparam int REG_COUNT = 16;
    localparam int PTR_W = 4;
    localparam logic [6:0] SLAVE_ADDR = 7'h5c;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
    // master phase tick in core clocks (four ticks per scl period: 800 ns at 50 ns core)
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] HALF_CNT = 8'(HALF_CYCLES - 1);
    localparam logic [7:0] CNT_ZERO = 8'h00;
endpackage : twi_pkg

// *** twi_if.sv ***
`timescale 1ns/1ps
interface twi_if;
    logic scl_o;
    logic scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    // open-drain wires with pull-ups: any enabled low driver wins
    wire scl = !(!scl_oe_n && !scl_o);
    wire sda = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));
    modport slave_end (input scl, input sda, output s_sda_o,
                       output s_sda_oe_n);
    modport master_end (input scl, input sda, output scl_o,
                        output scl_oe_n, output m_sda_o,
                        output m_sda_oe_n);
endinterface : twi_if

// *** twi_master.sv ***
`timescale 1ns/1ps
// simple command master: one byte per request, start/stop optional
module twi_master (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_start,
    input wire logic req_stop,
    input wire logic req_read,
    input wire logic req_nack,
    input wire logic [7:0] req_data,
    output logic req_ready,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_ack,
    twi_if.master_end bus
);
    import twi_pkg::*;

    typedef enum logic [4:0] {
        M_IDLE = 5'b00001,
        M_START = 5'b00010,
        M_BIT = 5'b00100,
        M_STOP = 5'b01000,
        M_DONE = 5'b10000
    } mstate_t;

    mstate_t st_reg;
    logic [7:0] cnt_reg;
    logic [3:0] bit_reg;
    logic [1:0] phase_reg;
    logic [8:0] tx_reg;
    logic [7:0] rx_reg;
    logic scl_low_reg, sda_low_reg, stop_pending_reg, ack_reg;
    logic sda_meta_reg, sda_sync_reg;
    logic tick;

    assign tick = (cnt_reg == CNT_ZERO);
    assign req_ready = (st_reg == M_IDLE);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
        end else begin
            sda_meta_reg <= bus.sda;
            sda_sync_reg <= sda_meta_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || st_reg == M_IDLE) cnt_reg <= HALF_CNT;
        else if (tick) cnt_reg <= HALF_CNT;
        else cnt_reg <= cnt_reg - 8'h01;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= M_IDLE;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            bit_reg <= BIT_ZERO;
            phase_reg <= 2'h0;
            tx_reg <= 9'h1ff;
            rx_reg <= BYTE_ZERO;
            stop_pending_reg <= 1'b0;
            ack_reg <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= BYTE_ZERO;
            resp_ack <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            case (st_reg)
                M_IDLE: if (req_valid) begin
                    // read bytes send 1s (released) plus ack/nack bit
                    tx_reg <= req_read ? {8'hff, req_nack}
                                       : {req_data, 1'b1};
                    stop_pending_reg <= req_stop;
                    bit_reg <= BIT_ZERO;
                    phase_reg <= 2'h0;
                    st_reg <= req_start ? M_START : M_BIT;
                end
                M_START: if (tick) begin
                    // release both, then pull sda with scl high [RL6]
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_low_reg <= 1'b0;
                        2'h1: scl_low_reg <= 1'b0;
                        2'h2: sda_low_reg <= 1'b1;
                        default: begin
                            scl_low_reg <= 1'b1;
                            phase_reg <= 2'h0;
                            st_reg <= M_BIT;
                        end
                    endcase
                end
                M_BIT: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_low_reg <= !tx_reg[8];
                        2'h1: scl_low_reg <= 1'b0;
                        2'h2: begin
                            // ninth bit is the ack, kept out of the byte
                            if (bit_reg == BIT_ACK) ack_reg <= !sda_sync_reg;
                            else rx_reg <= {rx_reg[6:0], sda_sync_reg};
                        end
                        default: begin
                            scl_low_reg <= 1'b1;
                            phase_reg <= 2'h0;
                            tx_reg <= {tx_reg[7:0], 1'b1};
                            if (bit_reg == BIT_ACK) begin
                                st_reg <= stop_pending_reg ? M_STOP : M_DONE;
                            end
                            bit_reg <= bit_reg + 4'h1;
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_low_reg <= 1'b1;
                        2'h1: scl_low_reg <= 1'b0;
                        default: begin
                            sda_low_reg <= 1'b0;
                            phase_reg <= 2'h0;
                            st_reg <= M_DONE;
                        end
                    endcase
                end
                M_DONE: begin
                    resp_valid <= 1'b1;
                    resp_data <= rx_reg;
                    resp_ack <= ack_reg;
                    st_reg <= M_IDLE;
                end
                default: st_reg <= M_IDLE;
            endcase
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe_n = !scl_low_reg;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = !sda_low_reg;
endmodule : twi_master

// *** twi_props.sv ***
`timescale 1ns/1ps
module twi_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic run_mode,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe_n
);
    import twi_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic scl_q, sda_q, first_reg, rd_reg, ok_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg;
    // raw bus samples; the slave itself sees them later
    wire rise = scl && !scl_q;
    wire start_c = scl && scl_q && sda_q && !sda;
    wire stop_c = scl && scl_q && !sda_q && sda;
    wire ack_slot = rise && cnt_reg == 4'h8;
    always_ff @(posedge core_clk) begin
        scl_q <= reset ? 1'b1 : scl;
        sda_q <= reset ? 1'b1 : sda;
    end
    always_ff @(posedge core_clk) begin
        if (reset || start_c) begin
            cnt_reg <= 4'h0;
        end else if (rise) begin
            cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rise && cnt_reg != 4'h8) begin
            sh_reg <= {sh_reg[6:0], sda};
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset || stop_c || start_c) begin
            first_reg <= start_c && !reset;
            ok_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else if (ack_slot && first_reg) begin
            first_reg <= 1'b0;
            ok_reg <= !run_mode && sh_reg[7:1] == SLAVE_ADDR;
            rd_reg <= sh_reg[0];
        end
    end
    sequence nack_seen;
        ack_slot && rd_reg && sda;
    endsequence
    sequence released8;
        s_sda_oe_n [*8];
    endsequence
    chk_addr_ack: assert property (ack_slot && first_reg |->
        s_sda_oe_n == (run_mode || sh_reg[7:1] != SLAVE_ADDR))
        else $error("address acknowledge wrong");
    chk_write_ack: assert property (
        ack_slot && !first_reg && ok_reg && !rd_reg |->
        (!s_sda_oe_n) throughout (scl [*2]))
        else $error("write byte not acknowledged");
    chk_foreign_quiet: assert property (
        rise && !ok_reg && !(first_reg && cnt_reg == 4'h8) |-> s_sda_oe_n)
        else $error("slave drives while not addressed");
    chk_read_release: assert property (
        ack_slot && rd_reg |-> s_sda_oe_n)
        else $error("slave drives master ack slot");
    chk_nack_release: assert property (nack_seen |=> released8)
        else $error("slave drives after nack");
    chk_sda_stable: assert property (
        scl && scl_q |-> $stable(s_sda_oe_n))
        else $error("slave changed sda with scl high");
    chk_start_quiet: assert property (start_c |=> released8)
        else $error("slave drives after start");
    chk_stop_quiet: assert property (stop_c |=> released8)
        else $error("slave drives after stop");
endmodule : twi_props

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import twi_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic run_mode = 1'b0;
    logic req_valid = 1'b0;
    logic req_start = 1'b0, req_stop = 1'b0, req_read = 1'b0;
    logic req_nack = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic req_ready, resp_valid, resp_ack, ak_b;
    logic [7:0] resp_data, rd_b;
    logic [REG_COUNT*8-1:0] regs_flat;
    logic [7:0] model [REG_COUNT];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    twi_if bus ();
    twi_slave i_twi_slave (.core_clk(core_clk), .reset(reset),
        .run_mode(run_mode), .bus(bus), .regs_flat(regs_flat));
    twi_master i_twi_master (.core_clk(core_clk), .reset(reset),
        .req_valid(req_valid), .req_start(req_start), .req_stop(req_stop),
        .req_read(req_read), .req_nack(req_nack), .req_data(req_data),
        .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_ack(resp_ack), .bus(bus));
    twi_props i_twi_props (.core_clk(core_clk), .reset(reset),
        .run_mode(run_mode), .scl(bus.scl), .sda(bus.sda),
        .s_sda_oe_n(bus.s_sda_oe_n));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // bytes take ~150 cycles each; ceiling is over twice the longest run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [127:0] flat();
        logic [127:0] f;
        for (int i = 0; i < REG_COUNT; i++) f[8*i+:8] = model[i];
        return f;
    endfunction : flat
    // flags: start, stop, read, nack
    task automatic op(input logic [3:0] f, input logic [7:0] d);
        int k;
        k = 0;
        while (req_ready !== 1'b1 && k < 999) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (k >= 999) err_count++; // a stuck handshake is a mismatch
        {req_start, req_stop, req_read, req_nack} = f;
        req_data = d;
        req_valid = 1'b1;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        k = 0;
        while (resp_valid !== 1'b1 && k < 999) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (k >= 999) err_count++; // no response within the limit
        rd_b = resp_data;
        ak_b = resp_ack;
    endtask : op
    task automatic wr_burst(input logic [7:0] a, input logic [3:0] p,
                            input int n);
        logic [3:0] q;
        logic [7:0] d;
        logic hit;
        q = p;
        hit = a[7:1] == SLAVE_ADDR && !run_mode;
        op(4'h8, a);
        check(ak_b, hit);
        op(4'h0, {4'h0, p});
        check(ak_b, hit);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            op((i == n - 1) ? 4'h4 : 4'h0, d);
            if (hit) model[q] = d;
            q = q + 4'h1;
            check(ak_b, hit);
            check(regs_flat, flat());
        end
    endtask : wr_burst
    task automatic rd_burst(input logic [3:0] p, input int n);
        logic [3:0] q;
        q = p;
        op(4'h8, {SLAVE_ADDR, 1'b0});
        op(4'h0, {4'h0, p});
        op(4'h8, {SLAVE_ADDR, 1'b1});
        check(ak_b, 1'b1);
        for (int i = 0; i < n; i++) begin
            op((i == n - 1) ? 4'h7 : 4'h2, 8'hff);
            check(rd_b, model[q]);
            q = q + 4'h1;
        end
    endtask : rd_burst
    initial begin
        void'($urandom(32'h46250a8d));
        repeat (20) @(posedge core_clk);
        #1;
        reset = 1'b0;
        foreach (model[i]) model[i] = 8'h00;
        check(regs_flat, flat());
        $display("test reset done");
        wr_burst(8'h00, 4'h3, 1);
        for (int j = 0; j < 8; j++) wr_burst({4'ha, 3'(j), 1'b0}, 4'(j), 1);
        $display("test foreign addresses done");
        wr_burst({SLAVE_ADDR, 1'b0}, 4'he, 18);
        wr_burst({SLAVE_ADDR, 1'b0}, 4'h0, 1);
        repeat (4) wr_burst({SLAVE_ADDR, 1'b0}, 4'($urandom),
                            1 + $urandom % 20);
        $display("test writes done");
        rd_burst(4'h0, 1);
        rd_burst(4'h9, 16);
        repeat (3) rd_burst(4'($urandom), 1 + $urandom % 16);
        $display("test reads done");
        run_mode = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        wr_burst({SLAVE_ADDR, 1'b0}, 4'h2, 2);
        run_mode = 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        foreach (model[i]) model[i] = 8'h00;
        check(regs_flat, flat());
        $display("test mode switch done");
        end_sim();
    end
endmodule : tb_top
